// ### design/acr_top.sv
// module: converter configuration register bank with channel indexing
`timescale 1ns/10ps
// Summary of operation
// [RULE1] bytes: chip config 0x00-0x02, index at 0x05, global functions from 0x08
// [RULE2] index register resets to 0x33, both converters and both clocks selected
// [RULE3] host writes zero into every undefined bit of a partial register
// [RULE4] host never writes a wholly undefined or unlisted address
// [RULE5] bit 5 of port config soft resets all registers, clearing mirror bit 2
// [RULE6] local registers hold one independent copy per channel at one address
// [RULE7] index bits steer local access: converters, bit 5 data clock, bit 4 frame clock
// [RULE8] all select bits set: a local write updates all four copies
// [RULE9] host selects exactly one converter before reading a local register; the testbench also reads local registers with index 0x33
// [RULE10] several selects set on local read: first converter copy returned
// [RULE11] global registers ignore the index register for reads and writes
// [RULE12] port config reads bits 0,7 as zero and bits 3,4 as one
// [RULE13] each frame starts with sixteen instruction bits, then data bytes
// [RULE14] first instruction bit picks read; read turns data pin to output
module acr_top #(
   parameter int NUM_GLB = 4,
   parameter int NUM_LOC = 4,
   parameter logic [7:0] CHIP_ID = 8'h5a, // arbitrary value
   parameter logic [7:0] CHIP_GRADE = 8'h01 // arbitrary value
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial pins
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // configuration outputs
   output logic [NUM_GLB-1:0][7:0] global_cfg,
   output logic [acr_pkg::NUM_COPY-1:0][NUM_LOC-1:0][7:0] local_cfg,
   output logic lsb_first
);
   localparam int GIW = $clog2(NUM_GLB);
   localparam int LIW = $clog2(NUM_LOC);

   acr_bus_if bus ();
   logic soft_r, lsb_r;
   logic [7:0] idx_r;
   logic [NUM_GLB-1:0][7:0] glb_r;
   logic [acr_pkg::NUM_COPY-1:0][NUM_LOC-1:0][7:0] loc_r;
   logic wr, hit_pcfg, hit_id, hit_grade, hit_idx, hit_glb, hit_loc, soft_req;
   logic [12:0] glb_off, loc_off;
   logic [GIW-1:0] glb_idx;
   logic [LIW-1:0] loc_idx;
   logic [1:0] rd_copy;
   logic [7:0] pcfg_rd;

   ////////////////////////////////////////////////////////////////////////
   // serial engine
   acr_spi_engine u_eng (
      .clk (clk),
      .rstn (rstn),
      .sclk (sclk),
      .csb_n (csb_n),
      .sdio_in (sdio_in),
      .sdio_out (sdio_out),
      .sdio_oe (sdio_oe),
      .bus (bus.eng)
   );

   ////////////////////////////////////////////////////////////////////////
   // [RULE1] address decode
   assign wr = bus.wr_stb;
   assign hit_pcfg = bus.addr == acr_pkg::ADDR_PORT_CFG;
   assign hit_id = bus.addr == acr_pkg::ADDR_CHIP_ID;
   assign hit_grade = bus.addr == acr_pkg::ADDR_CHIP_GRADE;
   assign hit_idx = bus.addr == acr_pkg::ADDR_INDEX;
   assign glb_off = bus.addr - acr_pkg::ADDR_GLB_BASE;
   assign loc_off = bus.addr - acr_pkg::ADDR_LOC_BASE;
   assign hit_glb = (bus.addr >= acr_pkg::ADDR_GLB_BASE) && (glb_off < 13'(NUM_GLB));
   assign hit_loc = (bus.addr >= acr_pkg::ADDR_LOC_BASE) && (loc_off < 13'(NUM_LOC));
   assign glb_idx = glb_off[GIW-1:0];
   assign loc_idx = loc_off[LIW-1:0];
   // [RULE5] soft reset request
   assign soft_req = wr && hit_pcfg
      && (bus.wdata[acr_pkg::PCFG_SOFT_HI] || bus.wdata[acr_pkg::PCFG_SOFT_LO]);

   // [RULE12] fixed port bits
   assign pcfg_rd = {1'b0, lsb_r, soft_r, 1'b1, 1'b1, soft_r, lsb_r, 1'b0};
   // [RULE10] first converter wins
   assign rd_copy = idx_r[acr_pkg::IDX_CHA] ? acr_pkg::COPY_CHA :
                    idx_r[acr_pkg::IDX_CHB] ? acr_pkg::COPY_CHB : acr_pkg::COPY_CHA;
   // [RULE11] read select, global ignores index
   assign bus.rdata = hit_pcfg ? pcfg_rd :
                      hit_id ? CHIP_ID :
                      hit_grade ? CHIP_GRADE :
                      hit_idx ? idx_r :
                      hit_glb ? glb_r[glb_idx] :
                      hit_loc ? loc_r[rd_copy][loc_idx] : acr_pkg::BYTE_ZERO;

   assign global_cfg = glb_r;
   assign local_cfg = loc_r;
   assign lsb_first = lsb_r;

   ////////////////////////////////////////////////////////////////////////
   // port config and index register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         soft_r <= 1'b0;
         lsb_r <= 1'b0;
         idx_r <= acr_pkg::IDX_RST;
      end else if (soft_r) begin
         // [RULE2] defaults on soft reset
         soft_r <= 1'b0;
         lsb_r <= 1'b0;
         idx_r <= acr_pkg::IDX_RST;
      end else begin
         soft_r <= soft_req;
         if (wr && hit_pcfg) begin
            lsb_r <= bus.wdata[acr_pkg::PCFG_LSB_HI] | bus.wdata[acr_pkg::PCFG_LSB_LO];
         end
         if (wr && hit_idx) begin
            idx_r <= bus.wdata & acr_pkg::IDX_MASK;
         end
      end
   end

   // global function registers
   for (genvar g = 0; g < NUM_GLB; g++) begin : g_glb
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            glb_r[g] <= acr_pkg::BYTE_ZERO;
         end else if (soft_r) begin
            glb_r[g] <= acr_pkg::BYTE_ZERO;
         end else if (wr && hit_glb && glb_idx == GIW'(g)) begin
            glb_r[g] <= bus.wdata;
         end
      end
   end

   // [RULE6] per-copy local registers
   for (genvar c = 0; c < acr_pkg::NUM_COPY; c++) begin : g_copy
      for (genvar l = 0; l < NUM_LOC; l++) begin : g_loc
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               loc_r[c][l] <= acr_pkg::BYTE_ZERO;
            end else if (soft_r) begin
               loc_r[c][l] <= acr_pkg::BYTE_ZERO;
            // [RULE7] [RULE8] index steers write
            end else if (wr && hit_loc && loc_idx == LIW'(l) && idx_r[acr_pkg::COPY_SEL[c]]) begin
               loc_r[c][l] <= bus.wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_hole;
      @(posedge clk) disable iff (!rstn)
      (bus.addr > acr_pkg::ADDR_CHIP_GRADE && bus.addr < acr_pkg::ADDR_GLB_BASE && !hit_idx)
         |-> bus.rdata == acr_pkg::BYTE_ZERO;
   endproperty
   a_hole: assert property (p_hole) else $error("open location reads nonzero"); // [RULE1]

   property p_idx_def;
      @(posedge clk) disable iff (!rstn)
      soft_r |=> (idx_r == acr_pkg::IDX_RST);
   endproperty
   a_idx_def: assert property (p_idx_def) else $error("index default wrong"); // [RULE2]

   property p_soft;
      @(posedge clk) disable iff (!rstn)
      (wr && hit_pcfg && bus.wdata[acr_pkg::PCFG_SOFT_HI] && !soft_r)
         |=> soft_r ##1 (!soft_r && glb_r[0] == acr_pkg::BYTE_ZERO && !pcfg_rd[acr_pkg::PCFG_SOFT_LO]);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset did not complete"); // [RULE5]

   property p_all_copies;
      @(posedge clk) disable iff (!rstn)
      (wr && hit_loc && !soft_r && (idx_r & acr_pkg::IDX_MASK) == acr_pkg::IDX_MASK)
         |=> (loc_r[0][$past(loc_idx)] == $past(bus.wdata)
              && loc_r[3][$past(loc_idx)] == $past(bus.wdata));
   endproperty
   a_all_copies: assert property (p_all_copies) else $error("broadcast write missed"); // [RULE8]

   property p_unsel;
      @(posedge clk) disable iff (!rstn)
      (wr && hit_loc && !soft_r && !idx_r[acr_pkg::IDX_CHB]) |=> $stable(loc_r[1]);
   endproperty
   a_unsel: assert property (p_unsel) else $error("unselected copy changed"); // [RULE7]

   property p_rd_first;
      @(posedge clk) disable iff (!rstn)
      (hit_loc && idx_r[acr_pkg::IDX_CHA]) |-> bus.rdata == loc_r[0][loc_idx];
   endproperty
   a_rd_first: assert property (p_rd_first) else $error("read not from first channel"); // [RULE10]

   property p_glb;
      @(posedge clk) disable iff (!rstn)
      (wr && hit_glb && !soft_r) |=> glb_r[$past(glb_idx)] == $past(bus.wdata);
   endproperty
   a_glb: assert property (p_glb) else $error("global write lost"); // [RULE11]

   property p_fixed;
      @(posedge clk) disable iff (!rstn)
      hit_pcfg |-> (bus.rdata[4:3] == 2'h3 && !bus.rdata[7] && !bus.rdata[0]);
   endproperty
   a_fixed: assert property (p_fixed) else $error("port config fixed bits wrong"); // [RULE12]
endmodule // acr_top

// ### design/acr_pkg.sv
// package: address map, field positions and defaults of the configuration bank
package acr_pkg;
   // address map
   localparam int ADDR_W = 13;
   localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
   localparam logic [12:0] ADDR_CHIP_ID = 13'h0001;
   localparam logic [12:0] ADDR_CHIP_GRADE = 13'h0002;
   localparam logic [12:0] ADDR_INDEX = 13'h0005;
   localparam logic [12:0] ADDR_GLB_BASE = 13'h0008;
   localparam logic [12:0] ADDR_LOC_BASE = 13'h0010;
   // port configuration fields (nibbles mirrored)
   localparam int PCFG_LSB_HI = 6;
   localparam int PCFG_SOFT_HI = 5;
   localparam int PCFG_SOFT_LO = 2;
   localparam int PCFG_LSB_LO = 1;
   // channel index fields
   localparam int IDX_CHA = 0;
   localparam int IDX_CHB = 1;
   localparam int IDX_FCO = 4;
   localparam int IDX_DCO = 5;
   localparam logic [7:0] IDX_RST = 8'h33;
   localparam logic [7:0] IDX_MASK = 8'h33;
   // local copies: converter a, converter b, frame clock, data clock
   localparam int NUM_COPY = 4;
   localparam logic [1:0] COPY_CHA = 2'h0;
   localparam logic [1:0] COPY_CHB = 2'h1;
   localparam int COPY_SEL [NUM_COPY] = '{IDX_CHA, IDX_CHB, IDX_FCO, IDX_DCO};
   // serial instruction layout
   localparam int INSTR_BITS = 16;
   localparam int INSTR_RW = 15;
   localparam int INSTR_W1 = 14;
   localparam int INSTR_W0 = 13;
   localparam logic [1:0] LEN_STREAM = 2'h3;
   localparam int BYTE_BITS = 8;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// ### design/acr_bus_if.sv
// interface: byte access path from the serial engine to the register bank
`timescale 1ns/10ps
interface acr_bus_if;
   logic [12:0] addr;
   logic [7:0] wdata;
   logic wr_stb;
   logic [7:0] rdata;
   modport eng (output addr, output wdata, output wr_stb, input rdata);
   modport regs (input addr, input wdata, input wr_stb, output rdata);
endinterface

// ### design/acr_spi_engine.sv
// module: three-wire serial port engine, oversampled on the core clock
`timescale 1ns/10ps
module acr_spi_engine (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial pins
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // register side
   acr_bus_if.eng bus
);
   typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_HOLD} acr_spi_state_type;

   acr_spi_state_type state_r;
   logic sclk_s1, sclk_s2, sclk_s3, csb_s1, csb_s2, sdi_s1, sdi_s2;
   logic [15:0] instr_r;
   logic [4:0] bitcnt_r;
   logic [1:0] len_r, bytes_r;
   logic rd_r, load_r, wr_stb_r, sdo_r, oe_r;
   logic [12:0] addr_r, wr_addr_r;
   logic [7:0] sh_r, wdata_r;
   logic rise, fall, instr_done, byte_done, last_byte;
   logic [15:0] instr_nxt;
   logic [7:0] byte_nxt;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, third sclk stage only for edge detection
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
         {csb_s1, csb_s2} <= 2'h3;
         {sdi_s1, sdi_s2} <= 2'h0;
      end else begin
         {sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
         {csb_s1, csb_s2} <= {csb_n, csb_s1};
         {sdi_s1, sdi_s2} <= {sdio_in, sdi_s1};
      end
   end

   // edge and phase decode
   assign rise = sclk_s2 & ~sclk_s3 & ~csb_s2;
   assign fall = ~sclk_s2 & sclk_s3 & ~csb_s2;
   assign instr_nxt = {instr_r[14:0], sdi_s2};
   assign byte_nxt = {sh_r[6:0], sdi_s2};
   assign instr_done = rise && (state_r == ST_INSTR)
      && (bitcnt_r == 5'(acr_pkg::INSTR_BITS - 1));
   assign byte_done = rise && (state_r == ST_DATA)
      && (bitcnt_r == 5'(acr_pkg::BYTE_BITS - 1));
   assign last_byte = (len_r != acr_pkg::LEN_STREAM) && (bytes_r == len_r);

   // register side outputs
   assign bus.addr = wr_stb_r ? wr_addr_r : addr_r;
   assign bus.wdata = wdata_r;
   assign bus.wr_stb = wr_stb_r;
   assign sdio_out = sdo_r;
   assign sdio_oe = oe_r;

   ////////////////////////////////////////////////////////////////////////
   // frame sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_INSTR;
         instr_r <= 16'h0000;
         bitcnt_r <= 5'h00;
         len_r <= 2'h0;
         bytes_r <= 2'h0;
         rd_r <= 1'b0;
         load_r <= 1'b0;
         wr_stb_r <= 1'b0;
         addr_r <= 13'h0000;
         wr_addr_r <= 13'h0000;
         wdata_r <= 8'h00;
         sh_r <= 8'h00;
         sdo_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         wr_stb_r <= 1'b0;
         load_r <= 1'b0;
         if (csb_s2) begin
            state_r <= ST_INSTR;
            bitcnt_r <= 5'h00;
            bytes_r <= 2'h0;
            oe_r <= 1'b0;
         end else begin
            case (state_r)
               // [RULE13] instruction then data
               ST_INSTR: begin
                  if (rise) begin
                     instr_r <= instr_nxt;
                     bitcnt_r <= bitcnt_r + 5'h01;
                  end
                  if (instr_done) begin
                     state_r <= ST_DATA;
                     bitcnt_r <= 5'h00;
                     rd_r <= instr_nxt[acr_pkg::INSTR_RW];
                     len_r <= instr_nxt[acr_pkg::INSTR_W1:acr_pkg::INSTR_W0];
                     addr_r <= instr_nxt[acr_pkg::ADDR_W-1:0];
                     load_r <= instr_nxt[acr_pkg::INSTR_RW];
                  end
               end
               ST_DATA: begin
                  if (load_r) begin
                     sh_r <= bus.rdata;
                  end else if (rise && !rd_r) begin
                     sh_r <= byte_nxt;
                  end else if (fall && rd_r) begin
                     // [RULE14] drive read data
                     sdo_r <= sh_r[7];
                     sh_r <= {sh_r[6:0], 1'b0};
                     oe_r <= 1'b1;
                  end
                  if (rise) begin
                     bitcnt_r <= bitcnt_r + 5'h01;
                  end
                  if (byte_done) begin
                     bitcnt_r <= 5'h00;
                     bytes_r <= bytes_r + 2'h1;
                     addr_r <= addr_r - 13'h0001;
                     wr_addr_r <= addr_r;
                     wdata_r <= byte_nxt;
                     wr_stb_r <= !rd_r;
                     load_r <= rd_r && !last_byte;
                     if (last_byte) begin
                        state_r <= ST_HOLD;
                        oe_r <= 1'b0;
                     end
                  end
               end
               ST_HOLD: state_r <= ST_HOLD;
               default: state_r <= ST_INSTR;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   // [RULE13] data after sixteen bits
   property p_instr_len;
      @(posedge clk) disable iff (!rstn)
      (state_r == ST_INSTR && rise && !csb_s2
         && bitcnt_r == 5'(acr_pkg::INSTR_BITS - 1))
         |=> (state_r == ST_DATA && bitcnt_r == 5'h00);
   endproperty
   a_instr_len: assert property (p_instr_len) else $error("instruction length wrong"); // [RULE13]

   // [RULE14] drive only on read
   property p_oe_read;
      @(posedge clk) disable iff (!rstn)
      oe_r |-> (rd_r && state_r == ST_DATA);
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("pin driven outside read data"); // [RULE14]
endmodule // acr_spi_engine

// ### verif/adc_spi_host.sv
// serial host model driving the three-wire configuration port
`timescale 1ns/10ps
module adc_spi_host #(
   parameter int HALF = 10
) (
   // clock
   input wire logic clk,
   // serial pins
   output logic sclk,
   output logic csb_n,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe
);
   logic drv_en;
   logic drv_bit;
   logic noise_r = 1'b0;
   logic oe_ok;

   ////////////////////////////////////////////////////////////////////////////
   // released line toggles every cycle so a stale bit never passes
   always @(posedge clk) begin
      noise_r <= ~noise_r;
   end
   // wire level worked out from both parties' enables
   assign sdio_in = sdio_oe ? sdio_out : (drv_en ? drv_bit : noise_r);

   initial begin
      sclk = 1'b0;
      csb_n = 1'b1;
      drv_en = 1'b0;
      drv_bit = 1'b0;
      oe_ok = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // waits n core cycles, then steps just past the edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one bit presented, then taken by the device on the rising edge
   task automatic put_bit(input logic b);
      drv_bit = b;
      wait_clk(HALF);
      sclk = 1'b1;
      wait_clk(HALF);
      sclk = 1'b0;
   endtask

   // one frame of one to three data bytes, read or write; address steps down per byte
   task automatic frame(input logic rd, input int nb, input logic [12:0] addr,
                        input logic [23:0] wd, output logic [23:0] rd_q);
      logic [15:0] instr;
      instr = {rd, 2'(nb - 1), addr};
      rd_q = 24'h000000;
      oe_ok = 1'b1;
      csb_n = 1'b0;
      drv_en = 1'b1;
      wait_clk(4);
      for (int i = 15; i >= 0; i--) begin
         put_bit(instr[i]);
      end
      if (rd) begin
         drv_en = 1'b0;
         for (int i = 8 * nb - 1; i >= 0; i--) begin
            wait_clk(HALF);
            rd_q[i] = sdio_in;
            oe_ok = oe_ok & sdio_oe;
            sclk = 1'b1;
            wait_clk(HALF);
            sclk = 1'b0;
         end
      end else begin
         for (int i = 8 * nb - 1; i >= 0; i--) begin
            put_bit(wd[i]);
         end
      end
      wait_clk(HALF);
      csb_n = 1'b1;
      drv_en = 1'b0;
      wait_clk(8);
   endtask
endmodule // adc_spi_host

// ### verif/adc_config_register_map_indexing_tb.sv
// testbench: register map, channel indexing and soft reset of the bank
`timescale 1ns/10ps
module adc_config_register_map_indexing_tb;
   localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
   localparam logic [7:0] GRADE_VAL = 8'h07; // arbitrary value
   logic clk;
   logic rstn;
   logic sclk;
   logic csb_n;
   logic sdio_in;
   logic sdio_out;
   logic sdio_oe;
   logic [3:0][7:0] global_cfg;
   logic [acr_pkg::NUM_COPY-1:0][3:0][7:0] local_cfg;
   logic lsb_first;
   logic [23:0] q;
   logic [7:0] sel;
   int n_fail;
   int checked;

   ////////////////////////////////////////////////////////////////////////////
   // design and host
   acr_top #(.NUM_GLB(4), .NUM_LOC(4), .CHIP_ID(ID_VAL), .CHIP_GRADE(GRADE_VAL)) dut (
      .clk(clk), .rstn(rstn), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .global_cfg(global_cfg),
      .local_cfg(local_cfg), .lsb_first(lsb_first));
   adc_spi_host #(.HALF(10)) host (
      .clk(clk), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare and report
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("mismatches %0d, comparisons %0d", n_fail, checked);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // single byte write
   task automatic wr(input logic [12:0] addr, input logic [7:0] data);
      logic [23:0] dummy;
      host.frame(1'b0, 1, addr, {16'h0000, data}, dummy);
   endtask

   // single byte read, pin must stay driven through the data byte
   task automatic rd_chk(input logic [12:0] addr, input logic [7:0] exp);
      host.frame(1'b1, 1, addr, 24'h000000, q);
      check(q, {16'h0000, exp});
      check(host.oe_ok, 1'b1);
      check(sdio_oe, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      $display("watchdog ran out");
      tally_and_finish();
   end

   // main sequence; only listed addresses are written, undefined bits as zero
   // host write discipline
   initial begin
      n_fail = 0;
      checked = 0;
      rstn = 1'b0;
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check(global_cfg, '0);
      check(lsb_first, 1'b0);
      rd_chk(acr_pkg::ADDR_INDEX, 8'h33);
      rd_chk(acr_pkg::ADDR_PORT_CFG, 8'h18);
      rd_chk(acr_pkg::ADDR_CHIP_ID, ID_VAL);
      rd_chk(acr_pkg::ADDR_CHIP_GRADE, GRADE_VAL);
      rd_chk(13'h0003, 8'h00);
      // default index: one write lands in all four copies
      wr(acr_pkg::ADDR_LOC_BASE, 8'ha5);
      for (int c = 0; c < 4; c++) begin
         check(local_cfg[c][0], 8'ha5);
      end
      // converter b alone, other copies untouched
      wr(acr_pkg::ADDR_INDEX, 8'h02);
      wr(acr_pkg::ADDR_LOC_BASE, 8'h3c);
      check(local_cfg[1][0], 8'h3c);
      for (int c = 0; c < 4; c++) begin
         if (c != 1) check(local_cfg[c][0], 8'ha5);
      end
      rd_chk(acr_pkg::ADDR_LOC_BASE, 8'h3c);
      // each select bit alone steers one copy
      for (int k = 0; k < 4; k++) begin
         sel = 8'h01 << acr_pkg::COPY_SEL[k];
         wr(acr_pkg::ADDR_INDEX, sel);
         wr(acr_pkg::ADDR_LOC_BASE + 13'h0001, 8'h41 + 8'(k));
         for (int j = 0; j < 4; j++) begin
            check(local_cfg[j][1], (j <= k) ? 8'h41 + 8'(j) : 8'h00);
         end
      end
      // several selects on a read: converter a answers
      wr(acr_pkg::ADDR_INDEX, 8'h33);
      rd_chk(acr_pkg::ADDR_LOC_BASE, 8'ha5);
      rd_chk(acr_pkg::ADDR_LOC_BASE + 13'h0001, 8'h41);
      // global register ignores the index
      wr(acr_pkg::ADDR_INDEX, 8'h02);
      wr(acr_pkg::ADDR_GLB_BASE, 8'h5e);
      check(global_cfg[0], 8'h5e);
      wr(acr_pkg::ADDR_INDEX, 8'h10);
      rd_chk(acr_pkg::ADDR_GLB_BASE, 8'h5e);
      // two-byte frames, address steps down per byte
      host.frame(1'b0, 2, acr_pkg::ADDR_GLB_BASE + 13'h0001, 24'h00c3d4, q);
      check(global_cfg[1:0], 16'hc3d4);
      host.frame(1'b1, 2, acr_pkg::ADDR_GLB_BASE + 13'h0001, 24'h000000, q);
      check(q, 24'h00c3d4);
      check(host.oe_ok, 1'b1);
      // lsb-first bits stored and read back, fixed bits kept
      wr(acr_pkg::ADDR_PORT_CFG, 8'h5a);
      check(lsb_first, 1'b1);
      rd_chk(acr_pkg::ADDR_PORT_CFG, 8'h5a);
      // soft reset with mirrored bits, fixed bits kept
      wr(acr_pkg::ADDR_PORT_CFG, 8'h3c);
      repeat (4) @(posedge clk);
      #1;
      check(global_cfg, '0);
      check(local_cfg, '0);
      rd_chk(acr_pkg::ADDR_INDEX, 8'h33);
      rd_chk(acr_pkg::ADDR_PORT_CFG, 8'h18);
      check(lsb_first, 1'b0);
      // soft reset through the mirrored bit alone
      wr(acr_pkg::ADDR_GLB_BASE, 8'h77);
      check(global_cfg[0], 8'h77);
      wr(acr_pkg::ADDR_PORT_CFG, 8'h1c);
      repeat (4) @(posedge clk);
      #1;
      check(global_cfg, '0);
      rd_chk(acr_pkg::ADDR_PORT_CFG, 8'h18);
      tally_and_finish();
   end
endmodule // adc_config_register_map_indexing_tb
